/* src/ubg_pkg.sv */
// Package for the serial port baud rate generator: map, fields, types
package ubg_pkg;

   // ==========================================================
   // Register byte offsets
   localparam logic [7:0] OFF_DIVISOR = 8'h00; // Divisor value
   localparam logic [7:0] OFF_DIV_CLR = 8'h04; // Clear alias
   localparam logic [7:0] OFF_DIV_SET = 8'h08; // Set alias
   localparam logic [7:0] OFF_DIV_INV = 8'h0c; // Invert alias
   localparam logic [7:0] OFF_MODE = 8'h10; // Serial mode register
   localparam logic [7:0] OFF_IPC_A = 8'h14; // Port 1 priority
   localparam logic [7:0] OFF_IPC_B = 8'h18; // Port 2 priority
   localparam logic [7:0] OFF_STATUS = 8'h1c; // Generator state

   // ==========================================================
   // Field layouts
   localparam int DIV_W = 16; // Divisor width
   localparam int MODE_ON_BIT = 15; // Port enable
   localparam int MODE_HS_BIT = 3; // High-speed select
   localparam int MODE_PEN_LO = 8; // Pin enable select low bit
   localparam int IP_LO = 2; // Priority field low bit
   localparam int IS_LO = 0; // Subpriority field low bit
   localparam logic [1:0] PEN_BCLK = 2'h3; // Pin enable code for clock
   localparam logic [2:0] IP_OFF = 3'h0; // Priority code: disabled

   // ==========================================================
   // Reset values and timing
   localparam logic [15:0] DIV_RST = 16'h0000; // Divisor reset
   localparam logic [3:0] OVS_NORMAL = 4'hf; // 16 ticks per bit, minus 1
   localparam logic [3:0] OVS_FAST = 4'h3; // 4 ticks per bit, minus 1
   localparam logic [1:0] RESP_OKAY = 2'h0; // AXI okay
   localparam logic [1:0] RESP_SLVERR = 2'h2; // AXI slave error

   // ==========================================================
   // Carrier types
   typedef struct packed {
      logic on; // Port enabled
      logic hs; // High-speed select
      logic [1:0] pen; // Pin enable select
   } ubg_mode_type;

   typedef struct packed {
      logic [2:0] prio; // Priority code
      logic [1:0] sub; // Subpriority code
   } ubg_irq_type;

endpackage

/* src/ubg_counter.sv */
// Free-running divisor counter and bit clock divider
`timescale 1ns/100ps
module ubg_counter (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Control
   input wire logic [15:0] divisor,
   input wire logic restart,
   input wire logic enable,
   input wire logic hs,
   // Outputs
   output logic tick,
   output logic bit_tick,
   output logic ovs_clk
);
   import ubg_pkg::*;

   // ==========================================================
   // Counter state
   logic [15:0] cnt_r; // Divisor counter
   logic [15:0] cnt_nxt;
   logic [3:0] sub_r; // Tick divider
   logic [3:0] sub_nxt;
   logic ovs_r; // Tick-rate clock level, 16x or 4x bit rate
   logic [15:0] half_w; // Counts spent high per period
   logic ovs_nxt;
   logic tick_r; // Tick pulse
   logic tick_nxt;
   logic bit_r; // Bit pulse
   logic bit_nxt;

   // High for the first half of each divisor period, so the pin runs
   // at the tick rate: 16x the bit rate in normal mode, 4x in high
   // speed. At divisor zero it stays low: the bus clock can't be copied
   assign half_w = 16'((17'(divisor) + 17'h00001) >> 1);

   // Next-state: wrap at divisor, restart on new divisor
   always_comb begin
      cnt_nxt = cnt_r;
      sub_nxt = sub_r;
      tick_nxt = 1'b0;
      bit_nxt = 1'b0;
      if (restart || !enable) begin
         // Restarting avoids waiting out the old period
         cnt_nxt = '0;
         sub_nxt = '0;
      end else if (cnt_r == divisor) begin
         cnt_nxt = '0;
         tick_nxt = 1'b1;
         if (sub_r == (hs ? OVS_FAST : OVS_NORMAL)) begin
            sub_nxt = '0;
            bit_nxt = 1'b1;
         end else begin
            sub_nxt = sub_r + 4'h1;
         end
      end else begin
         cnt_nxt = cnt_r + 16'h0001;
      end
      // Clock level follows the counter position; low while disabled
      ovs_nxt = enable && (cnt_nxt < half_w);
   end

   // Register the counter state
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cnt_r <= '0;
         sub_r <= '0;
         ovs_r <= 1'b0;
         tick_r <= 1'b0;
         bit_r <= 1'b0;
      end else begin
         cnt_r <= cnt_nxt;
         sub_r <= sub_nxt;
         ovs_r <= ovs_nxt;
         tick_r <= tick_nxt;
         bit_r <= bit_nxt;
      end
   end

   assign tick = tick_r;
   assign bit_tick = bit_r;
   assign ovs_clk = ovs_r;
endmodule

/* src/ubg_top.sv */
// Baud rate generator top: AXI4-Lite registers, counter, clock pin
//
// Notes on behaviour
// - 3-bit priority per port, zero disables
// - 2-bit subpriority per port, levels 0-3
// - Free-running 16-bit counter, period from divisor
// - Normal mode: clock over 16 times divisor+1
// - High-speed mode: clock over 4 times divisor+1
// - Divisor write clears counter immediately
// - Enabled, pin select 11: output tick-rate clock, 16x normal, 4x high-speed
// - Sleep holds clock pin low
// - Pin select 11 with port enabled forces pin to output
// - Divisor 16 bits, resets zero, upper reserved
// - Clear, set, invert write-only aliases
`timescale 1ns/100ps
module ubg_top (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // AXI4-Lite write address
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   // AXI4-Lite write data
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // AXI4-Lite write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // AXI4-Lite read address
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   // AXI4-Lite read data
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Power state
   input wire logic sleep,
   // General-purpose port settings for the shared pin
   input wire logic port_direction_latch,
   input wire logic port_data_latch,
   // Shared clock pin
   output logic baud_clock_out,
   output logic baud_clock_out_oe,
   // Rate outputs for the serial engine
   output logic bit_tick,
   // Interrupt settings for the controller
   output ubg_pkg::ubg_irq_type port1_irq,
   output ubg_pkg::ubg_irq_type port2_irq,
   output logic port1_irq_enabled,
   output logic port2_irq_enabled
);
   import ubg_pkg::*;

   // ==========================================================
   // Registers
   logic [15:0] div_r; // Baud divisor
   logic [15:0] div_nxt;
   ubg_mode_type mode_r; // Serial mode register
   ubg_mode_type mode_nxt;
   ubg_irq_type ipa_r; // Port 1 priority
   ubg_irq_type ipa_nxt;
   ubg_irq_type ipb_r; // Port 2 priority
   ubg_irq_type ipb_nxt;
   logic restart_r; // Counter restart pulse
   logic restart_nxt;

   // ==========================================================
   // Bus handshake state
   logic aw_hold_r; // Write address captured
   logic aw_hold_nxt;
   logic [7:0] aw_addr_r; // Captured write address
   logic [7:0] aw_addr_nxt;
   logic w_hold_r; // Write data captured
   logic w_hold_nxt;
   logic [31:0] w_data_r; // Captured write data
   logic [31:0] w_data_nxt;
   logic [3:0] w_strb_r; // Captured strobes
   logic [3:0] w_strb_nxt;
   logic bvalid_r; // Write response pending
   logic bvalid_nxt;
   logic [1:0] bresp_r; // Write response code
   logic [1:0] bresp_nxt;
   logic rvalid_r; // Read data pending
   logic rvalid_nxt;
   logic [31:0] rdata_r; // Read data
   logic [31:0] rdata_nxt;
   logic [1:0] rresp_r; // Read response code
   logic [1:0] rresp_nxt;

   // ==========================================================
   // Pin input synchroniser: three stages, second and third agree
   logic [2:0] slp_sync_r; // Sleep synchroniser chain
   logic slp_r; // Filtered sleep level
   logic slp_nxt;

   // ==========================================================
   // Counter wires
   logic ovs_clk; // Tick-rate clock level, 16x or 4x bit rate
   logic bclk_mode; // Pin dedicated to clock
   logic do_write; // Write commits this cycle
   logic [15:0] wmask; // Byte-lane mask, low half
   logic [15:0] wval; // Lane-masked write value

   // Filtered sleep: a change counts once stages two and three agree
   always_comb begin
      slp_nxt = slp_r;
      if (slp_sync_r[1] == slp_sync_r[2]) begin
         slp_nxt = slp_sync_r[2];
      end
   end

   // Register the synchroniser
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         slp_sync_r <= 3'h0;
         slp_r <= 1'b0;
      end else begin
         slp_sync_r <= {slp_sync_r[1:0], sleep};
         slp_r <= slp_nxt;
      end
   end

   // Both halves of a write must be in hand before commit
   assign do_write = aw_hold_r && w_hold_r && !bvalid_r;
   assign wmask = {{8{w_strb_r[1]}}, {8{w_strb_r[0]}}};
   assign wval = w_data_r[15:0] & wmask;

   // Write channel: capture address and data in either order
   always_comb begin
      aw_hold_nxt = aw_hold_r;
      aw_addr_nxt = aw_addr_r;
      w_hold_nxt = w_hold_r;
      w_data_nxt = w_data_r;
      w_strb_nxt = w_strb_r;
      bvalid_nxt = bvalid_r;
      bresp_nxt = bresp_r;
      if (s_axi_awvalid && s_axi_awready) begin
         aw_hold_nxt = 1'b1;
         aw_addr_nxt = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         w_hold_nxt = 1'b1;
         w_data_nxt = s_axi_wdata;
         w_strb_nxt = s_axi_wstrb;
      end
      if (do_write) begin
         aw_hold_nxt = 1'b0;
         w_hold_nxt = 1'b0;
         bvalid_nxt = 1'b1;
         unique case (aw_addr_r)
            OFF_DIVISOR, OFF_DIV_CLR, OFF_DIV_SET, OFF_DIV_INV,
            OFF_MODE, OFF_IPC_A, OFF_IPC_B: begin
               bresp_nxt = RESP_OKAY;
            end
            default: begin
               // Status and unmapped words refuse writes
               bresp_nxt = RESP_SLVERR;
            end
         endcase
      end else if (bvalid_r && s_axi_bready) begin
         bvalid_nxt = 1'b0;
      end
   end

   // Register map updates and the divisor alias operations
   always_comb begin
      div_nxt = div_r;
      mode_nxt = mode_r;
      ipa_nxt = ipa_r;
      ipb_nxt = ipb_r;
      restart_nxt = 1'b0;
      if (do_write) begin
         unique case (aw_addr_r)
            OFF_DIVISOR: begin
               // Upper reserved bits are dropped
               div_nxt = (div_r & ~wmask) | wval;
               restart_nxt = 1'b1;
            end
            OFF_DIV_CLR: begin
               div_nxt = div_r & ~wval;
               restart_nxt = 1'b1;
            end
            OFF_DIV_SET: begin
               div_nxt = div_r | wval;
               restart_nxt = 1'b1;
            end
            OFF_DIV_INV: begin
               div_nxt = div_r ^ wval;
               restart_nxt = 1'b1;
            end
            OFF_MODE: begin
               if (w_strb_r[1]) begin
                  mode_nxt.on = w_data_r[MODE_ON_BIT];
                  mode_nxt.pen = w_data_r[MODE_PEN_LO +: 2];
               end
               if (w_strb_r[0]) begin
                  mode_nxt.hs = w_data_r[MODE_HS_BIT];
               end
            end
            OFF_IPC_A: begin
               if (w_strb_r[0]) begin
                  ipa_nxt.prio = w_data_r[IP_LO +: 3];
                  ipa_nxt.sub = w_data_r[IS_LO +: 2];
               end
            end
            OFF_IPC_B: begin
               if (w_strb_r[0]) begin
                  ipb_nxt.prio = w_data_r[IP_LO +: 3];
                  ipb_nxt.sub = w_data_r[IS_LO +: 2];
               end
            end
            default: begin
               // Nothing stored for other words
               div_nxt = div_r;
            end
         endcase
      end
   end

   // Read channel: one read in flight, answer one cycle after address
   always_comb begin
      rvalid_nxt = rvalid_r;
      rdata_nxt = rdata_r;
      rresp_nxt = rresp_r;
      if (s_axi_arvalid && s_axi_arready) begin
         rvalid_nxt = 1'b1;
         rresp_nxt = RESP_OKAY;
         rdata_nxt = 32'h0000_0000;
         unique case (s_axi_araddr)
            OFF_DIVISOR: begin
               rdata_nxt[DIV_W-1:0] = div_r;
            end
            OFF_MODE: begin
               rdata_nxt[MODE_ON_BIT] = mode_r.on;
               rdata_nxt[MODE_PEN_LO +: 2] = mode_r.pen;
               rdata_nxt[MODE_HS_BIT] = mode_r.hs;
            end
            OFF_IPC_A: begin
               rdata_nxt[4:0] = ipa_r;
            end
            OFF_IPC_B: begin
               rdata_nxt[4:0] = ipb_r;
            end
            OFF_STATUS: begin
               // Live generator state for software
               rdata_nxt[2:0] = {slp_r, bclk_mode, ovs_clk};
            end
            OFF_DIV_CLR, OFF_DIV_SET, OFF_DIV_INV: begin
               // Write-only aliases read as zero
               rdata_nxt = 32'h0000_0000;
            end
            default: begin
               rresp_nxt = RESP_SLVERR;
            end
         endcase
      end else if (rvalid_r && s_axi_rready) begin
         rvalid_nxt = 1'b0;
      end
   end

   // Register all bus and map state
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         div_r <= DIV_RST;
         mode_r <= '0;
         ipa_r <= '0;
         ipb_r <= '0;
         restart_r <= 1'b0;
         aw_hold_r <= 1'b0;
         aw_addr_r <= 8'h00;
         w_hold_r <= 1'b0;
         w_data_r <= 32'h0000_0000;
         w_strb_r <= 4'h0;
         bvalid_r <= 1'b0;
         bresp_r <= RESP_OKAY;
         rvalid_r <= 1'b0;
         rdata_r <= 32'h0000_0000;
         rresp_r <= RESP_OKAY;
      end else begin
         div_r <= div_nxt;
         mode_r <= mode_nxt;
         ipa_r <= ipa_nxt;
         ipb_r <= ipb_nxt;
         restart_r <= restart_nxt;
         aw_hold_r <= aw_hold_nxt;
         aw_addr_r <= aw_addr_nxt;
         w_hold_r <= w_hold_nxt;
         w_data_r <= w_data_nxt;
         w_strb_r <= w_strb_nxt;
         bvalid_r <= bvalid_nxt;
         bresp_r <= bresp_nxt;
         rvalid_r <= rvalid_nxt;
         rdata_r <= rdata_nxt;
         rresp_r <= rresp_nxt;
      end
   end

   // Handshake outputs: ready while nothing is held
   assign s_axi_awready = !aw_hold_r;
   assign s_axi_wready = !w_hold_r;
   assign s_axi_arready = !rvalid_r;
   assign s_axi_bvalid = bvalid_r;
   assign s_axi_bresp = bresp_r;
   assign s_axi_rvalid = rvalid_r;
   assign s_axi_rdata = rdata_r;
   assign s_axi_rresp = rresp_r;

   // ==========================================================
   // Counter; disabling the port also resets it
   ubg_counter u_counter (
      .clk(clk),
      .rst(rst),
      .divisor(div_r),
      .restart(restart_r),
      .enable(mode_r.on),
      .hs(mode_r.hs),
      .tick(),
      .bit_tick(bit_tick),
      .ovs_clk(ovs_clk)
   );

   // ==========================================================
   // Pin mux: dedicated clock overrides the port latches
   assign bclk_mode = mode_r.on && (mode_r.pen == PEN_BCLK);

   always_comb begin
      if (bclk_mode) begin
         baud_clock_out_oe = 1'b1;
         // Held low in sleep rather than toggling
         baud_clock_out = ovs_clk && !slp_r;
      end else begin
         // Ordinary port pin: direction latch set means input
         baud_clock_out_oe = !port_direction_latch;
         baud_clock_out = port_data_latch;
      end
   end

   // ==========================================================
   // Interrupt settings; priority zero means disabled
   assign port1_irq = ipa_r;
   assign port2_irq = ipb_r;
   assign port1_irq_enabled = (ipa_r.prio != IP_OFF);
   assign port2_irq_enabled = (ipb_r.prio != IP_OFF);
endmodule

/* sim/ubg_checker.sv */
// Checker: bus answers, tick spacing, pin ownership, priority gates
`timescale 1ns/100ps
module ubg_checker (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Bus handshakes
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Pin and rate
   input wire logic port_data_latch,
   input wire logic port_direction_latch,
   input wire logic baud_clock_out,
   input wire logic baud_clock_out_oe,
   input wire logic bit_tick,
   // Priority outputs
   input wire ubg_pkg::ubg_irq_type port1_irq,
   input wire ubg_pkg::ubg_irq_type port2_irq,
   input wire logic port1_irq_enabled,
   input wire logic port2_irq_enabled
);
   import ubg_pkg::*;
   // ==========================================================
   // Common clock and reset for every property
   default clocking @(posedge clk);
   endclocking
   default disable iff (rst);
   // Address and data taken at one edge
   sequence s_both_taken;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   // Fastest bit rate leaves three quiet cycles
   sequence s_tick_quiet;
      !bit_tick [*3];
   endsequence
   // ==========================================================
   // Assertions
   chk_wr_answer: assert property (s_both_taken |-> ##2 s_axi_bvalid)
      else $error("write answer late");
   chk_b_hold: assert property (s_axi_bvalid && !s_axi_bready
      |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write answer dropped");
   chk_r_hold: assert property (s_axi_rvalid && !s_axi_rready
      |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read answer dropped");
   chk_rd_answer: assert property (s_axi_arvalid && s_axi_arready
      |=> s_axi_rvalid)
      else $error("read answer late");
   chk_tick_gap: assert property (bit_tick |=> s_tick_quiet)
      else $error("bit ticks too close");
   chk_pin_owner: assert property (!baud_clock_out_oe
      |-> port_direction_latch)
      else $error("pin released against latch");
   chk_pin_mirror: assert property (!baud_clock_out_oe
      |-> baud_clock_out == port_data_latch)
      else $error("released pin not from latch");
   chk_irq1_gate: assert property (port1_irq_enabled
      == (port1_irq.prio != IP_OFF))
      else $error("port 1 enable wrong");
   chk_irq2_gate: assert property (port2_irq_enabled
      == (port2_irq.prio != IP_OFF))
      else $error("port 2 enable wrong");
endmodule

bind ubg_top ubg_checker u_chk (.clk, .rst, .s_axi_awvalid,
   .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
   .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
   .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .port_data_latch,
   .port_direction_latch, .baud_clock_out, .baud_clock_out_oe,
   .bit_tick, .port1_irq, .port2_irq, .port1_irq_enabled,
   .port2_irq_enabled);

/* sim/ubg_irda_model.sv */
// Infrared encoder stand-in: measures the shared clock pin period
`timescale 1ns/100ps
module ubg_irda_model (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Shared clock pin
   input wire logic bclk,
   input wire logic bclk_oe,
   // Last rising-edge spacing in clocks
   output int period
);
   logic last_r; // Pin level one clock ago
   int cnt_r; // Clocks since last rising edge
   // ==========================================================
   // Encoder only listens while the pin is driven
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         last_r <= 1'b0;
         cnt_r <= 0;
         period <= 0;
      end else begin
         cnt_r <= cnt_r + 1;
         last_r <= bclk && bclk_oe;
         // Rising edge closes one period
         if (bclk && bclk_oe && !last_r) begin
            period <= cnt_r + 1;
            cnt_r <= 0;
         end
      end
   end
endmodule

/* sim/testbench.sv */
// Testbench: registers, rates, restart, clock pin and sleep
`timescale 1ns/100ps
module testbench;
   import ubg_pkg::*;
   // ==========================================================
   // Signals
   logic clk, rst, sleep, pdir, pdat, bclk, oe, tick, en1, en2;
   logic awvalid, awready, wvalid, wready, bvalid, bready;
   logic arvalid, arready, rvalid, rready;
   logic [7:0] awaddr, araddr;
   logic [31:0] wdata, rdata, rdv;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp, resp;
   logic [2:0] pv;
   ubg_irq_type irq1, irq2;
   int mismatches, compares, w, g, n, period;
   // Alias data and expected divisor after each
   logic [31:0] ad [3] = '{32'h1004, 32'h8001, 32'h0231};
   logic [31:0] ae [3] = '{32'h0230, 32'h8231, 32'h8000};
   // Divisor, expected bit period
   logic [31:0] dv [3] = '{32'h2, 32'h2, 32'h0};
   logic [31:0] ge [3] = '{32'd48, 32'd12, 32'd4};
   ubg_top dut (.clk(clk), .rst(rst), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .sleep(sleep), .port_direction_latch(pdir),
      .port_data_latch(pdat), .baud_clock_out(bclk),
      .baud_clock_out_oe(oe), .bit_tick(tick), .port1_irq(irq1),
      .port2_irq(irq2), .port1_irq_enabled(en1),
      .port2_irq_enabled(en2));
   ubg_irda_model u_ir (.clk(clk), .rst(rst), .bclk(bclk),
      .bclk_oe(oe), .period(period));
   // ==========================================================
   // Clock and hang guard
   always #50 clk = ~clk;
   initial begin
      repeat (100000) @(posedge clk);
      mismatches++;
      wrap_up();
   end
   // Verdict and end of run
   task automatic wrap_up;
      if (mismatches == 0 && compares > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   // Word compare
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         mismatches++;
         $display("wrong value at %0t: got %h exp %h", $time, got, exp);
      end
   endtask
   // One write; channels released as each is taken
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic ta, tw, tb;
      int k;
      k = 0;
      tb = 1'b0;
      @(posedge clk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!tb && k < 50) begin
         @(negedge clk);
         ta = awvalid && awready;
         tw = wvalid && wready;
         tb = bvalid;
         resp = bresp;
         @(posedge clk);
         k++;
         if (ta) awvalid <= 1'b0;
         if (tw) wvalid <= 1'b0;
      end
      bready <= 1'b0;
      if (!tb) begin
         mismatches++;
         wrap_up();
      end
   endtask
   // One read; data and response kept in rdv and resp
   task automatic rd(input logic [7:0] a);
      logic ta, tr;
      int k;
      k = 0;
      tr = 1'b0;
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      while (!tr && k < 50) begin
         @(negedge clk);
         ta = arvalid && arready;
         tr = rvalid;
         rdv = rdata;
         resp = rresp;
         @(posedge clk);
         k++;
         if (ta) arvalid <= 1'b0;
      end
      rready <= 1'b0;
      if (!tr) begin
         mismatches++;
         wrap_up();
      end
   endtask
   // Wait for a tick (wt), then time to the next one (gp)
   task automatic tick_gap(output int wt, output int gp);
      wt = 0;
      gp = 0;
      do begin
         @(negedge clk);
         wt++;
      end while (!tick && wt < 20000);
      do begin
         @(negedge clk);
         gp++;
      end while (!tick && gp < 20000);
      // A tick that never comes ends the run
      if (wt >= 20000 || gp >= 20000) begin
         mismatches++;
         wrap_up();
      end
   endtask
   // ==========================================================
   // Main sequence
   initial begin
      clk = 0;
      rst = 1;
      {sleep, pdat, awvalid, wvalid, bready, arvalid, rready} = '0;
      pdir = 1;
      {awaddr, araddr, wdata} = '0;
      wstrb = 4'hf;
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      rd(OFF_DIVISOR);
      chk(rdv, 32'h0);
      chk({31'h0, en1}, 32'h0);
      wr(OFF_DIVISOR, 32'hffff1234);
      rd(OFF_DIVISOR);
      chk(rdv, 32'h1234);
      // Clear, set and invert aliases in turn
      for (int i = 0; i < 3; i++) begin
         wr(OFF_DIV_CLR + 8'(4 * i), ad[i]);
         rd(OFF_DIVISOR);
         chk(rdv, ae[i]);
      end
      rd(OFF_DIV_SET);
      chk(rdv, 32'h0);
      wr(OFF_STATUS, 32'h1);
      chk({30'h0, resp}, {30'h0, RESP_SLVERR});
      rd(8'h20);
      chk({rdv[29:0], resp}, {30'h0, RESP_SLVERR});
      // Every priority code, both ports, opposite values
      for (int p = 0; p < 8; p++) begin
         pv = 3'(p);
         wr(OFF_IPC_A, {27'h0, pv, pv[1:0]});
         wr(OFF_IPC_B, {27'h0, ~pv, ~pv[1:0]});
         chk({27'h0, irq1}, {27'h0, pv, pv[1:0]});
         chk({27'h0, irq2}, {27'h0, ~pv, ~pv[1:0]});
         chk({30'h0, en1, en2}, {30'h0, pv != 0, pv != 7});
         rd(OFF_IPC_B);
         chk(rdv, {27'h0, ~pv, ~pv[1:0]});
      end
      // Normal and high-speed bit periods
      for (int i = 0; i < 3; i++) begin
         wr(OFF_DIVISOR, dv[i]);
         wr(OFF_MODE, (i > 0) ? 32'h8008 : 32'h8000);
         tick_gap(w, g);
         chk(32'(g), ge[i]);
      end
      // Long period cut short by a new divisor
      wr(OFF_DIVISOR, 32'h00ff);
      wr(OFF_MODE, 32'h8000);
      repeat (300) @(posedge clk);
      wr(OFF_DIVISOR, 32'h0001);
      tick_gap(w, g);
      chk(32'(w <= 40), 32'h1);
      chk(32'(g), 32'd32);
      // Port off: counter held, no ticks
      wr(OFF_MODE, 32'h0);
      repeat (4) @(negedge clk);
      n = 0;
      repeat (200) begin
         @(negedge clk);
         n += tick;
      end
      chk(32'(n), 32'h0);
      // Pin owned: forced out, 16x clock to the encoder
      @(posedge clk);
      wr(OFF_DIVISOR, 32'h3);
      wr(OFF_MODE, 32'h8300);
      rd(OFF_MODE);
      chk(rdv, 32'h8300);
      pdir <= 1'b0;
      repeat (40) @(negedge clk);
      chk({31'h0, oe}, 32'h1);
      chk(32'(period), 32'd4);
      @(posedge clk);
      pdir <= 1'b1;
      sleep <= 1'b1;
      repeat (30) @(negedge clk);
      chk({31'h0, oe}, 32'h1);
      repeat (16) begin
         @(negedge clk);
         chk({31'h0, bclk}, 32'h0);
      end
      @(posedge clk);
      sleep <= 1'b0;
      wr(OFF_MODE, 32'h8000);
      pdat <= 1'b1;
      repeat (2) @(negedge clk);
      chk({30'h0, oe, bclk}, 32'h1);
      wrap_up();
   end
endmodule
